// [bench/dau_cmd_source.sv]
`timescale 1ns/1ps
module dau_cmd_source
(
    // Clock
    input wire logic i_clk,
    // Byte request from the test sequence
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    // Command byte toward the block
    output logic [7:0] o_cmd
);
    // One byte leaves every cycle, and an empty slot carries no command bits.
    always_ff @(posedge i_clk)
    begin
        o_cmd <= i_valid ? i_byte : 8'h00;
    end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import dau_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic src_v = 1'b0;
    logic [7:0] src_b = 8'h00;
    logic [7:0] cmd;
    logic idle = 1'b0;
    logic [DAU_MEM_W-1:0] space = 16'h1234;
    logic [6:0] upset = 7'h00;
    logic mupset = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    int miscompares = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    dau_cmd_source src (.i_clk(clk), .i_valid(src_v), .i_byte(src_b), .o_cmd(cmd));

    dau_debug_counters #(.NBLK(7)) dut (.i_clk(clk), .i_srst(srst), .i_cmd(cmd), .i_idle_sent(idle),
        .i_free_space(space), .i_blk_upset(upset), .i_master_upset(mupset), .i_cfg_wr(wr),
        .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata));

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Reads n bytes, least significant first; data follows the address by one edge.
    task automatic rdchk(input logic [4:0] idx, input int n, input logic [47:0] exp);
        logic [47:0] val;
        val = '0;
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            addr <= {idx, 3'(k)};
            @(posedge clk);
            #1;
            val[8*k +: 8] = rdata;
        end
        chk(val, exp);
    endtask

    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        @(posedge clk);
        src_v <= 1'b1;
        src_b <= b;
    endtask

    // Stops the byte stream and lets the last byte reach the block.
    task automatic flush();
        @(posedge clk);
        src_v <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic hit(input logic [6:0] b, input logic m, input int n);
        @(posedge clk);
        upset <= b;
        mupset <= m;
        repeat (n) @(posedge clk);
        upset <= 7'h00;
        mupset <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdchk(5'h06, 4, 48'h0);
        repeat (3) send(8'hfc);
        send(8'h01);
        flush();
        for (int k = 2; k < 8; k++)
        begin
            rdchk(5'(k), 1, 48'h3);
            rdchk(5'(8 + k), 1, 48'h2);
        end
        rdchk(5'h00, 1, 48'h1);
        rdchk(5'h01, 1, 48'h0);
        rdchk(5'h08, 1, 48'h0);
        rdchk(5'h15, 2, 48'h1234);
        @(posedge clk);
        idle <= 1'b1;
        repeat (2) @(posedge clk);
        idle <= 1'b0;
        rdchk(5'h12, 6, 48'h2);
        wrb(8'h30, 8'h55);
        rdchk(5'h06, 1, 48'h3);
        send(8'h42);
        flush();
        rdchk(5'h06, 4, 48'h0);
        rdchk(5'h07, 4, 48'h0);
        rdchk(5'h01, 1, 48'h1);
        rdchk(5'h12, 6, 48'h0);
        rdchk(5'h0e, 1, 48'h2);
        rdchk(5'h0f, 1, 48'h2);
        @(posedge clk);
        space <= 16'hbeef;
        idle <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        send(8'h01);
        send(8'h00);
        send(8'h00);
        send(8'h02);
        send(8'h20);
        flush();
        rdchk(5'h11, 2, 48'h3);
        rdchk(5'h09, 1, 48'h2);
        rdchk(5'h13, 6, 48'h0);
        rdchk(5'h14, 2, 48'hbeef);
        rdchk(5'h15, 2, 48'hbeef);
        wrb(8'hb0, 8'h00);
        rdchk(5'h16, 1, 48'h0);
        rdchk(5'h17, 1, 48'h0);
        hit(7'h7f, 1'b0, 1);
        for (int b = 0; b < 7; b++)
        begin
            rdchk(5'(8'h18 + b), 1, 48'h1);
        end
        hit(7'h01, 1'b1, 1);
        rdchk(5'h18, 1, 48'h2);
        hit(7'h00, 1'b1, 1);
        rdchk(5'h18, 1, 48'h3);
        hit(7'h04, 1'b0, 300);
        rdchk(5'h1a, 1, 48'hff);
        wrb(8'hd0, 8'h00);
        rdchk(5'h1a, 1, 48'h0);
        wrb(8'hd0, 8'h07);
        rdchk(5'h1a, 1, 48'h7);
        rdchk(5'h1f, 1, 48'h0);
        conclude();
    end
endmodule

// [common/dau_pkg.sv]
package dau_pkg;

    // Command byte bit positions.
    localparam int DAU_CMD_CALIB = 7;
    localparam int DAU_CMD_SYNC = 6;
    localparam int DAU_CMD_SNAP = 5;
    localparam int DAU_CMD_VETO = 4;
    localparam int DAU_CMD_NZS = 3;
    localparam int DAU_CMD_HDR = 2;
    localparam int DAU_CMD_FERST = 1;
    localparam int DAU_CMD_BXRST = 0;
    localparam int DAU_NCMD = 8;

    // Counter widths, indexed by command bit.
    localparam int DAU_CNT_W [DAU_NCMD] = '{32, 32, 48, 32, 48, 32, 32, 32};
    localparam int DAU_BX_W = 12;
    localparam int DAU_IDLE_W = 48;
    localparam int DAU_MEM_W = 16;
    localparam int DAU_UPSET_W = 8;
    localparam int DAU_NBLK = 7;
    localparam int DAU_GLB_BLK = 0;

    // Register map: address is {index[4:0], byte[2:0]}, byte 0 least significant.
    localparam logic [4:0] DAU_IDX_CNT = 5'h00;
    localparam logic [4:0] DAU_IDX_CNT_COPY = 5'h08;
    localparam logic [4:0] DAU_IDX_BX = 5'h10;
    localparam logic [4:0] DAU_IDX_BX_COPY = 5'h11;
    localparam logic [4:0] DAU_IDX_IDLE = 5'h12;
    localparam logic [4:0] DAU_IDX_IDLE_COPY = 5'h13;
    localparam logic [4:0] DAU_IDX_MEM = 5'h14;
    localparam logic [4:0] DAU_IDX_MEM_COPY = 5'h15;
    localparam logic [4:0] DAU_IDX_OVF = 5'h16;
    localparam logic [4:0] DAU_IDX_OVF_COPY = 5'h17;
    localparam logic [4:0] DAU_IDX_UPSET = 5'h18;

    // Reset values.
    localparam logic [47:0] DAU_CNT_RST = 48'h0;
    localparam logic [7:0] DAU_OVF_RST = 8'h00;
    localparam logic [7:0] DAU_UPSET_RST = 8'h00;

    function automatic logic [47:0] dau_mask(input int w);
        logic [48:0] m;
        m = (49'h1 << w) - 49'h1;
        return m[47:0];
    endfunction

endpackage

// [hw/dau_debug_counters.sv]
`timescale 1ns/1ps
// Summary of operation
// - One counter per command bit of byte.
// - Front-end reset clears counters, idle, not itself.
// - Overflow bits gathered in one shared register.
// - Overflow and upset registers writable; counters read-only.
// - Writing zero clears overflow bits not set that cycle.
// - Capture command copies every counter to copy.
// - Capture also copies overflow register same cycle.
// - Copies survive front-end reset; capture only changes.
// - Crossing, idle, space and copies are readable.
// - Crossing count and space ignore front-end reset.
// - Only crossing count cleared by crossing reset.
// - Idle count increments per transmitted idle packet.
// - Space register follows free memory every cycle.
// - Copy mismatch rewrites all copies with vote plus one.
// - Each block upset counter increments by one.
// - Upset counters saturate at 255.
// - Upset counters writable; zero write resets them.
// - At most one upset counted per counter per cycle.
// - Master block errors count in global block.
// - Upset counters are triplicated and voted.
// - Flip-flops triplicated with voting where built.
// - Front-end reset clears counters; crossing reset crossing.
module dau_debug_counters
    import dau_pkg::*;
#(
    parameter int NBLK = DAU_NBLK
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Command byte, one per cycle
    input wire logic [7:0] i_cmd,
    // Readout status
    input wire logic i_idle_sent,
    input wire logic [DAU_MEM_W-1:0] i_free_space,
    // Upset detection
    input wire logic [NBLK-1:0] i_blk_upset,
    input wire logic i_master_upset,
    // Configuration register port
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata
);

    if (NBLK < 1 || NBLK > 8)
    begin : g_chk
        $error("dau_debug_counters: NBLK must be 1 to 8");
    end

    logic [47:0] cnt_r [DAU_NCMD];
    logic [47:0] copy_r [DAU_NCMD];
    logic [DAU_NCMD-1:0] ovf_r;
    logic [DAU_NCMD-1:0] ovf_copy_r;
    logic [DAU_NCMD-1:0] ovf_set;
    logic [DAU_NCMD-1:0] cnt_clr;
    logic [DAU_BX_W-1:0] bx_r;
    logic [DAU_BX_W-1:0] bx_copy_r;
    logic [DAU_IDLE_W-1:0] idle_r;
    logic [DAU_IDLE_W-1:0] idle_copy_r;
    logic [DAU_MEM_W-1:0] mem_r;
    logic [DAU_MEM_W-1:0] mem_copy_r;
    logic [DAU_UPSET_W-1:0] upset_val [NBLK];
    logic [47:0] rd_word;
    logic [4:0] rd_idx;
    logic snap;
    logic fe_rst;
    logic ovf_wr;

    assign snap = i_cmd[DAU_CMD_SNAP];
    assign fe_rst = i_cmd[DAU_CMD_FERST];
    assign rd_idx = i_cfg_addr[7:3];
    assign ovf_wr = i_cfg_wr && i_cfg_addr == {DAU_IDX_OVF, 3'h0};

    function automatic logic [7:0] pick_byte(input logic [47:0] w, input logic [2:0] b);
        logic [47:0] s;
        s = w >> {b, 3'h0};
        return (b > 3'h5) ? 8'h00 : s[7:0];
    endfunction

    // The front-end reset clears every command counter except its own.
    always_comb
    begin
        for (int k = 0; k < DAU_NCMD; k++)
        begin
            cnt_clr[k] = fe_rst && (k != DAU_CMD_FERST);
            ovf_set[k] = i_cmd[k] && !cnt_clr[k] && cnt_r[k] == dau_mask(DAU_CNT_W[k]);
        end
    end

    // Command counters, indexed by command bit.
    always_ff @(posedge i_clk)
    begin
        for (int k = 0; k < DAU_NCMD; k++)
        begin
            if (i_srst)
            begin
                cnt_r[k] <= DAU_CNT_RST;
            end
            else if (cnt_clr[k])
            begin
                cnt_r[k] <= DAU_CNT_RST;
            end
            else if (i_cmd[k])
            begin
                cnt_r[k] <= (cnt_r[k] + 48'h1) & dau_mask(DAU_CNT_W[k]);
            end
        end
    end

    // Shared overflow register; a new overflow wins over a clearing write.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ovf_r <= DAU_OVF_RST;
        end
        else if (ovf_wr && i_cfg_wdata == 8'h00)
        begin
            ovf_r <= ovf_set;
        end
        else
        begin
            ovf_r <= ovf_r | ovf_set;
        end
    end

    // Copies change only on the capture command.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int k = 0; k < DAU_NCMD; k++)
            begin
                copy_r[k] <= DAU_CNT_RST;
            end
            ovf_copy_r <= DAU_OVF_RST;
            bx_copy_r <= '0;
            idle_copy_r <= '0;
            mem_copy_r <= '0;
        end
        else if (snap)
        begin
            for (int k = 0; k < DAU_NCMD; k++)
            begin
                copy_r[k] <= cnt_r[k];
            end
            ovf_copy_r <= ovf_r;
            bx_copy_r <= bx_r;
            idle_copy_r <= idle_r;
            mem_copy_r <= mem_r;
        end
    end

    // Crossing count advances each cycle and wraps at its width.
    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_cmd[DAU_CMD_BXRST])
        begin
            bx_r <= '0;
        end
        else
        begin
            bx_r <= bx_r + {{(DAU_BX_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst || fe_rst)
        begin
            idle_r <= '0;
        end
        else if (i_idle_sent)
        begin
            idle_r <= idle_r + {{(DAU_IDLE_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            mem_r <= '0;
        end
        else
        begin
            mem_r <= i_free_space;
        end
    end

    // Per-block upset counters; the global block also takes master errors.
    for (genvar b = 0; b < NBLK; b++)
    begin : g_upset
        logic err;
        logic wr;
        assign err = i_blk_upset[b] | ((b == DAU_GLB_BLK) ? i_master_upset : 1'b0);
        assign wr = i_cfg_wr && i_cfg_addr == {DAU_IDX_UPSET + 5'(b), 3'h0};
        dau_tmr_sat_cnt #(
            .W(DAU_UPSET_W)
        ) u_cnt (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_err(err),
            .i_wr(wr),
            .i_wdata(i_cfg_wdata),
            .o_value(upset_val[b])
        );
    end

    // Read decode; counters and copies have no write path.
    always_comb
    begin
        rd_word = 48'h0;
        if (rd_idx < DAU_IDX_CNT_COPY)
        begin
            rd_word = cnt_r[rd_idx[2:0]];
        end
        else if (rd_idx < DAU_IDX_BX)
        begin
            rd_word = copy_r[rd_idx[2:0]];
        end
        else if (rd_idx >= DAU_IDX_UPSET && {1'b0, rd_idx} < 6'(DAU_IDX_UPSET) + 6'(NBLK))
        begin
            rd_word = {40'h0, upset_val[3'(rd_idx - DAU_IDX_UPSET)]};
        end
        else
        begin
            unique case (rd_idx)
                DAU_IDX_BX: rd_word = {36'h0, bx_r};
                DAU_IDX_BX_COPY: rd_word = {36'h0, bx_copy_r};
                DAU_IDX_IDLE: rd_word = idle_r;
                DAU_IDX_IDLE_COPY: rd_word = idle_copy_r;
                DAU_IDX_MEM: rd_word = {32'h0, mem_r};
                DAU_IDX_MEM_COPY: rd_word = {32'h0, mem_copy_r};
                DAU_IDX_OVF: rd_word = {40'h0, ovf_r};
                DAU_IDX_OVF_COPY: rd_word = {40'h0, ovf_copy_r};
                default: rd_word = 48'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_cfg_rdata <= 8'h00;
        end
        else
        begin
            o_cfg_rdata <= pick_byte(rd_word, i_cfg_addr[2:0]);
        end
    end

    sync_count_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_cmd[DAU_CMD_SYNC] && !fe_rst) |=> cnt_r[DAU_CMD_SYNC] == (($past(cnt_r[DAU_CMD_SYNC]) + 48'h1)
            & 48'h0000_ffff_ffff))
        else $error("Sync counter did not advance.");

    fe_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        fe_rst |=> (cnt_r[DAU_CMD_CALIB] == 48'h0 && idle_r == '0
            && cnt_r[DAU_CMD_FERST] == (($past(cnt_r[DAU_CMD_FERST]) + 48'h1) & 48'h0000_ffff_ffff)))
        else $error("Front-end reset clearing is wrong.");

    ovf_wrap_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_cmd[DAU_CMD_VETO] && !fe_rst && cnt_r[DAU_CMD_VETO] == 48'hffff_ffff_ffff)
            |=> (ovf_r[DAU_CMD_VETO] && cnt_r[DAU_CMD_VETO] == 48'h0))
        else $error("Wrap did not set overflow.");

    ovf_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (ovf_wr && i_cfg_wdata == 8'h00 && ovf_set == '0) |=> ovf_r == 8'h00)
        else $error("Overflow register not cleared by zero write.");

    ovf_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (fe_rst && !ovf_wr) |=> (ovf_r & $past(ovf_r)) == $past(ovf_r))
        else $error("Front-end reset cleared overflow bits.");

    snap_take_a: assert property (@(posedge i_clk) disable iff (i_srst)
        snap |=> (copy_r[DAU_CMD_HDR] == $past(cnt_r[DAU_CMD_HDR]) && ovf_copy_r == $past(ovf_r)
            && bx_copy_r == $past(bx_r)))
        else $error("Capture did not copy present values.");

    snap_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !snap |=> ($stable(copy_r[DAU_CMD_NZS]) && $stable(idle_copy_r) && $stable(ovf_copy_r)))
        else $error("Copy changed without capture.");

    bx_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_cmd[DAU_CMD_BXRST] |=> bx_r == '0 ##1 bx_r == 12'h001 || $past(i_cmd[DAU_CMD_BXRST]))
        else $error("Crossing reset handling is wrong.");

    mem_follow_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_srst |=> mem_r == $past(i_free_space))
        else $error("Space register does not follow input.");

    glb_master_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_master_upset && !i_cfg_wr && upset_val[DAU_GLB_BLK] != 8'hff)
            |=> upset_val[DAU_GLB_BLK] == $past(upset_val[DAU_GLB_BLK]) + 8'h01)
        else $error("Master upset not counted in global block.");

endmodule

// [hw/dau_tmr_sat_cnt.sv]
`timescale 1ns/1ps
module dau_tmr_sat_cnt
    import dau_pkg::*;
#(
    parameter int W = DAU_UPSET_W
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Error event and software write
    input wire logic i_err,
    input wire logic i_wr,
    input wire logic [W-1:0] i_wdata,
    // Voted value
    output logic [W-1:0] o_value
);

    if (W < 1 || W > 8)
    begin : g_chk
        $error("dau_tmr_sat_cnt: W must be 1 to 8");
    end

    logic [W-1:0] cp0_r;
    logic [W-1:0] cp1_r;
    logic [W-1:0] cp2_r;
    logic [W-1:0] voted;
    logic [W-1:0] base;
    logic [W-1:0] cnt_nxt;
    logic mism;
    logic hit;

    always_comb
    begin
        voted = (cp0_r & cp1_r) | (cp1_r & cp2_r) | (cp0_r & cp2_r);
        mism = (cp0_r != cp1_r) || (cp1_r != cp2_r);
        base = i_wr ? i_wdata : voted;
        // A copy disagreement is itself an upset and is merged into one count per cycle.
        hit = i_err | mism;
        cnt_nxt = (hit && base != {W{1'b1}}) ? base + {{(W-1){1'b0}}, 1'b1} : base;
    end

    // All three copies are rewritten every cycle from the next count, built on the voted value or the write data.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cp0_r <= DAU_UPSET_RST[W-1:0];
            cp1_r <= DAU_UPSET_RST[W-1:0];
            cp2_r <= DAU_UPSET_RST[W-1:0];
        end
        else
        begin
            cp0_r <= cnt_nxt;
            cp1_r <= cnt_nxt;
            cp2_r <= cnt_nxt;
        end
    end

    assign o_value = voted;

    sat_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (voted == {W{1'b1}} && !i_wr) |=> (o_value == {W{1'b1}}))
        else $error("Saturated upset counter changed.");

    write_zero_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_wr && i_wdata == '0 && !hit) |=> (o_value == '0) ##1 (o_value == '0 || $past(hit) || $past(i_wr)))
        else $error("Write of zero did not clear the upset counter.");

    copy_fix_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mism |=> (cp0_r == cp1_r && cp1_r == cp2_r))
        else $error("Copies were not rewritten after a mismatch.");

endmodule
